// [rtl/sarat_pkg.sv]
// Package of constants and types for the converter result and threshold block.
package sarat_pkg;

    // =========================================================================
    // Register bus
    // =========================================================================
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  OFF_RESULT     = 8'h00;
    localparam logic [7:0]  OFF_RESULT_HI  = 8'h04;
    localparam logic [7:0]  OFF_THRESH     = 8'h08;
    localparam logic [7:0]  OFF_MODE       = 8'h0c;
    localparam logic [7:0]  OFF_MODE_SET   = 8'h10;
    localparam logic [7:0]  OFF_MODE_CLR   = 8'h14;
    localparam logic [7:0]  OFF_CHAN       = 8'h18;
    localparam logic [7:0]  OFF_IRQ_STS    = 8'h1c;
    localparam logic [7:0]  OFF_IRQ_MSK    = 8'h20;
    localparam logic [7:0]  OFF_PORT       = 8'h24;

    // =========================================================================
    // Field layout and reset values
    // =========================================================================
    localparam int          RES_W          = 10;
    localparam int          RES_PAD        = 6;
    localparam int          CHAN_W         = 4;
    localparam int          MODE_EN        = 7;
    localparam int          MODE_FR_LO     = 2;
    localparam int          MODE_FR_HI     = 4;
    localparam logic [7:0]  MODE_WMASK     = 8'hbc;
    localparam logic [7:0]  MODE_RST       = 8'h00;
    localparam logic [7:0]  THRESH_RST     = 8'h00;
    localparam int          STS_DONE       = 0;
    localparam int          STS_PF         = 1;
    localparam int          STS_W          = 2;

    // =========================================================================
    // Timing: conversion clocks per conversion and clock dividers
    // =========================================================================
    localparam int          CONV_CLKS      = 19;
    localparam logic [3:0]  SAMPLE_LAST    = 4'(CONV_CLKS - RES_W - 1);
    localparam logic [3:0]  IDX_MSB        = 4'(RES_W - 1);
    localparam logic [3:0]  DIV16_LAST     = 4'hf;
    localparam logic [3:0]  DIV8_LAST      = 4'h7;
    localparam logic [3:0]  DIV4_LAST      = 4'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_BITS
    } sarat_state_t;

    typedef struct packed {
        sarat_state_t                st;
        logic [3:0]                  div;
        logic [3:0]                  cnt;
        logic [3:0]                  idx;
        logic [RES_W-1:0]            approx;
        logic [RES_W+RES_PAD-1:0]    result;
        logic [7:0]                  thresh;
        logic [7:0]                  mode;
        logic [CHAN_W-1:0]           chan;
        logic [STS_W-1:0]            sts;
        logic [STS_W-1:0]            msk;
        logic [DATA_W-1:0]           rdata;
    } sarat_regs_t;

    localparam sarat_regs_t REGS_RST = '0;

endpackage : sarat_pkg

// [rtl/sarat_top.sv]
// Digital control, result path and power-fail threshold of a 10-bit APPROXIMATION_REG converter.
`timescale 1ns/1ns

module sarat_top #(
    parameter int NUM_CH = 16
) (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst,
    input  wire logic [sarat_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [sarat_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [sarat_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                         i_cmp_hi,
    input  wire logic                         i_prescale_tick,
    input  wire logic [15:0]                  i_pin_levels,
    output logic      [sarat_pkg::RES_W-1:0]  o_dac_code,
    output logic      [sarat_pkg::CHAN_W-1:0] o_chan_sel,
    output logic                              o_sample,
    output logic                              o_busy,
    output logic      [15:0]                  o_port_data,
    output logic                              o_irq
);
    import sarat_pkg::*;

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic [15:0] onehot16(input logic [3:0] n);
        logic [15:0] v;
        v = 16'h0001 << n;
        return v;
    endfunction : onehot16

    function automatic logic [3:0] div_last(input logic [1:0] fr);
        logic [3:0] v;
        unique case (fr)
            2'b00:   v = DIV16_LAST;
            2'b01:   v = DIV8_LAST;
            2'b10:   v = DIV4_LAST;
            2'b11:   v = DIV4_LAST;
        endcase
        return v;
    endfunction : div_last

    sarat_regs_t        q;
    sarat_regs_t        d;
    logic               conv_tick;
    logic               wr_abort;
    logic [RES_W-1:0]   lsb_word;
    logic [7:0]         res_hi;
    logic [7:0]         wd_byte;
    logic [15:0]        ana_mask;
    logic [15:0]        bit_sel;
    logic [15:0]        trial_bit;

    assign lsb_word = {q.approx[RES_W-1:1], i_cmp_hi};
    assign res_hi   = q.result[15:8];
    assign wd_byte  = i_wdata[7:0];
    assign bit_sel   = onehot16({1'b0, i_wdata[2:0]});
    assign trial_bit = onehot16(q.idx);

    // =========================================================================
    // Conversion clock
    // =========================================================================
    // The prescaler tick is taken as already one cycle wide and synchronous.
    always_comb begin
        if (q.mode[MODE_FR_LO+1:MODE_FR_LO] == 2'b11) begin
            conv_tick = i_prescale_tick;
        end else begin
            conv_tick = (q.div == div_last(q.mode[MODE_FR_LO+1:MODE_FR_LO]));
        end
    end

    // =========================================================================
    // Next-state logic
    // =========================================================================
    always_comb begin
        d        = q;
        d.rdata  = '0;
        wr_abort = 1'b0;

        // Bus writes come first so that hardware events below win over clears.
        if (i_wr) begin
            unique case (i_addr)
                OFF_MODE: begin
                    d.mode   = wd_byte & MODE_WMASK;
                    wr_abort = 1'b1;
                end
                OFF_MODE_SET: begin
                    d.mode   = (q.mode | bit_sel[7:0]) & MODE_WMASK;
                    wr_abort = 1'b1;
                end
                OFF_MODE_CLR: begin
                    d.mode   = q.mode & ~bit_sel[7:0];
                    wr_abort = 1'b1;
                end
                OFF_CHAN: begin
                    // The whole word is checked so that a wide value cannot alias a channel.
                    if (i_wdata < 32'(NUM_CH)) begin
                        d.chan = i_wdata[CHAN_W-1:0];
                    end
                    wr_abort = 1'b1;
                end
                OFF_THRESH: d.thresh = wd_byte;
                OFF_IRQ_STS: d.sts = q.sts & ~i_wdata[STS_W-1:0];
                OFF_IRQ_MSK: d.msk = i_wdata[STS_W-1:0];
                default: ; // The result registers and unmapped offsets ignore writes.
            endcase
        end

        if (q.st == ST_IDLE || conv_tick) begin
            d.div = 4'h0;
        end else begin
            d.div = q.div + 4'h1;
        end

        unique case (q.st)
            ST_IDLE: begin
                d.cnt    = 4'h0;
                d.approx = '0;
                d.st     = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                if (conv_tick) begin
                    if (q.cnt == SAMPLE_LAST) begin
                        d.st  = ST_BITS;
                        d.idx = IDX_MSB;
                    end else begin
                        d.cnt = q.cnt + 4'h1;
                    end
                end
            end
            ST_BITS: begin
                if (conv_tick) begin
                    d.approx[q.idx] = i_cmp_hi;
                    if (q.idx == 4'h0) begin
                        d.result = {lsb_word, {RES_PAD{1'b0}}};
                        d.sts[STS_DONE] = 1'b1;
                        if (lsb_word[RES_W-1:RES_W-8] < q.thresh) begin
                            d.sts[STS_PF] = 1'b1;
                        end
                        d.st     = ST_SAMPLE;
                        d.cnt    = 4'h0;
                        d.approx = '0;
                    end else begin
                        d.idx = q.idx - 4'h1;
                    end
                end
            end
        endcase

        // A setting outside 00 in the upper time pair is refused by holding the converter idle.
        if (wr_abort || !d.mode[MODE_EN] ||
            d.mode[MODE_FR_HI+1:MODE_FR_HI] != 2'b00) begin
            d.st = ST_IDLE;
        end

        if (i_rd) begin
            unique case (i_addr)
                OFF_RESULT:    d.rdata = {16'h0000, q.result};
                OFF_RESULT_HI: d.rdata = {24'h000000, res_hi};
                OFF_THRESH:    d.rdata = {24'h000000, q.thresh};
                OFF_MODE:      d.rdata = {24'h000000, q.mode};
                OFF_CHAN:      d.rdata = {28'h0000000, q.chan};
                OFF_IRQ_STS:   d.rdata = {30'h00000000, q.sts};
                OFF_IRQ_MSK:   d.rdata = {30'h00000000, q.msk};
                OFF_PORT:      d.rdata = {16'h0000, o_port_data};
                default:       d.rdata = '0;
            endcase
        end
    end

    // The result resets to zero only for tidiness; software must not rely on it.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    always_comb begin
        if (q.st == ST_BITS) begin
            o_dac_code = q.approx | trial_bit[RES_W-1:0];
        end else begin
            o_dac_code = q.approx;
        end
    end

    assign ana_mask    = q.mode[MODE_EN] ? onehot16(q.chan) : 16'h0000;
    assign o_port_data = i_pin_levels & ~ana_mask;
    assign o_chan_sel  = q.chan;
    assign o_sample    = (q.st == ST_SAMPLE);
    assign o_busy      = (q.st != ST_IDLE);
    assign o_rdata     = q.rdata;
    assign o_irq       = |(q.sts & q.msk);

    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_last_bit;
        q.st == ST_BITS && q.idx == 4'h0 && conv_tick;
    endsequence

    sequence s_enter_bits;
        q.st == ST_BITS && $past(q.st) != ST_BITS;
    endsequence

    property p_msb_first;
        s_enter_bits |-> q.idx == IDX_MSB;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("Bit decision did not start at the MSB.");

    property p_copy_on_lsb;
        s_last_bit |=> q.result == {$past(lsb_word), 6'h00};
    endproperty
    a_copy_on_lsb: assert property (p_copy_on_lsb)
        else $error("Result not loaded when the LSB was decided.");

    property p_low_zero;
        q.result[RES_PAD-1:0] == 6'h00;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("Low result bits are not zero.");

    property p_result_ro;
        (i_wr && i_addr == OFF_RESULT && !(q.st == ST_BITS && conv_tick)) |=> $stable(q.result);
    endproperty
    a_result_ro: assert property (p_result_ro)
        else $error("A write changed the result register.");

    property p_high_view;
        (i_rd && i_addr == OFF_RESULT_HI) |=> o_rdata == {24'h000000, $past(res_hi)};
    endproperty
    a_high_view: assert property (p_high_view)
        else $error("High-byte view returned the wrong value.");

    property p_abort;
        (i_wr && (i_addr == OFF_CHAN || i_addr == OFF_MODE)) |=> q.st == ST_IDLE ##1 q.st != ST_BITS;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Conversion not restarted after a mode or channel write.");

    property p_power_fail;
        (s_last_bit and (lsb_word[9:2] < q.thresh)) |=> q.sts[STS_PF];
    endproperty
    a_power_fail: assert property (p_power_fail)
        else $error("Power-fail status not set below threshold.");

    property p_thresh_wr;
        (i_wr && i_addr == OFF_THRESH) |=> q.thresh == $past(wd_byte);
    endproperty
    a_thresh_wr: assert property (p_thresh_wr)
        else $error("Threshold write not stored.");

    property p_port_mask;
        q.mode[MODE_EN] |-> o_port_data[q.chan] == 1'b0;
    endproperty
    a_port_mask: assert property (p_port_mask)
        else $error("Selected analog pin leaked onto the digital port.");

    property p_stop;
        (i_wr && i_addr == OFF_MODE && !i_wdata[MODE_EN]) |=> q.st == ST_IDLE [*2];
    endproperty
    a_stop: assert property (p_stop)
        else $error("Conversion did not stop on clearing the enable bit.");

    property p_mode_rsv;
        (q.mode & ~MODE_WMASK) == 8'h00;
    endproperty
    a_mode_rsv: assert property (p_mode_rsv)
        else $error("Reserved mode bits are set.");

    property p_div16;
        (q.mode[3:2] == 2'b00 && q.st != ST_IDLE && conv_tick) |-> q.div == DIV16_LAST;
    endproperty
    a_div16: assert property (p_div16)
        else $error("Conversion tick not on the sixteenth clock.");

    property p_bit_order;
        (q.st == ST_BITS && conv_tick && q.idx != 4'h0) |=> q.idx == $past(q.idx) - 4'h1;
    endproperty
    a_bit_order: assert property (p_bit_order)
        else $error("Bit index did not step down by one.");

    property p_dac_trial;
        q.st == ST_BITS |-> o_dac_code[q.idx] == 1'b1;
    endproperty
    a_dac_trial: assert property (p_dac_trial)
        else $error("Trial bit missing from the DAC code.");

    property p_result_hold;
        !(q.st == ST_BITS && q.idx == 4'h0 && conv_tick) |=> $stable(q.result);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("Result changed outside a conversion end.");

    property p_done_flag;
        s_last_bit |=> q.sts[STS_DONE];
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("Done status not set at conversion end.");

    property p_rdata_low;
        (i_rd && i_addr == OFF_RESULT) |=> o_rdata[RES_PAD-1:0] == 6'h00;
    endproperty
    a_rdata_low: assert property (p_rdata_low)
        else $error("Result read returned nonzero low bits.");

    property p_result_rd;
        (i_rd && i_addr == OFF_RESULT) |=> o_rdata == {16'h0000, $past(q.result)};
    endproperty
    a_result_rd: assert property (p_result_rd)
        else $error("Result read returned the wrong word.");

    property p_no_power_fail;
        (s_last_bit and (!q.sts[STS_PF] && lsb_word[RES_W-1:RES_W-8] >= q.thresh))
            |=> !q.sts[STS_PF];
    endproperty
    a_no_power_fail: assert property (p_no_power_fail)
        else $error("Power-fail status set at or above threshold.");

    property p_thresh_rd;
        (i_rd && i_addr == OFF_THRESH) |=> o_rdata == {24'h000000, $past(q.thresh)};
    endproperty
    a_thresh_rd: assert property (p_thresh_rd)
        else $error("Threshold read returned the wrong value.");

    property p_chan_range;
        int'(o_chan_sel) < NUM_CH;
    endproperty
    a_chan_range: assert property (p_chan_range)
        else $error("Selected channel is out of range.");

    property p_port_pass;
        !q.mode[MODE_EN] |-> o_port_data == i_pin_levels;
    endproperty
    a_port_pass: assert property (p_port_pass)
        else $error("Digital port masked while the converter is stopped.");

    property p_mode_rd;
        (i_rd && i_addr == OFF_MODE) |=> o_rdata == {24'h000000, $past(q.mode)};
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("Mode read returned the wrong value.");

    property p_run_needs_en;
        q.st != ST_IDLE |-> q.mode[MODE_EN];
    endproperty
    a_run_needs_en: assert property (p_run_needs_en)
        else $error("Converter running with the enable bit clear.");

    property p_fr_hi_idle;
        q.mode[MODE_FR_HI+1:MODE_FR_HI] != 2'b00 |-> q.st == ST_IDLE;
    endproperty
    a_fr_hi_idle: assert property (p_fr_hi_idle)
        else $error("Converter running with a refused time setting.");

    property p_div8;
        (q.mode[3:2] == 2'b01 && q.st != ST_IDLE && conv_tick) |-> q.div == DIV8_LAST;
    endproperty
    a_div8: assert property (p_div8)
        else $error("Conversion tick not on the eighth clock.");

endmodule : sarat_top

// [tb/tb.sv]
// Self-checking testbench for the converter result and threshold block.
`timescale 1ns/1ns

module tb;
    import sarat_pkg::*;

    // =========================================================================
    // Signals
    // =========================================================================
    logic                 clk;
    logic                 rst;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
    logic                 wr;
    logic                 rd;
    logic [DATA_W-1:0]    rdata;
    logic                 cmp_hi;
    logic                 ptick;
    logic [15:0]          pins;
    logic [RES_W-1:0]     dac;
    logic [CHAN_W-1:0]    chan;
    logic                 smp;
    logic                 busy;
    logic [15:0]          port_data;
    logic                 irq;
    logic [RES_W-1:0]     analog;
    logic [DATA_W-1:0]    got;
    int                   bad_count;
    int                   samples_checked;
    int                   pcnt;

    sarat_top dut (
        .i_sys_clk       (clk),
        .i_rst           (rst),
        .i_addr          (addr),
        .i_wdata         (wdata),
        .i_wr            (wr),
        .i_rd            (rd),
        .o_rdata         (rdata),
        .i_cmp_hi        (cmp_hi),
        .i_prescale_tick (ptick),
        .i_pin_levels    (pins),
        .o_dac_code      (dac),
        .o_chan_sel      (chan),
        .o_sample        (smp),
        .o_busy          (busy),
        .o_port_data     (port_data),
        .o_irq           (irq)
    );

    // =========================================================================
    // Clock, analog side and prescaler
    // =========================================================================
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The comparator lags the trial code by one clock, which even the fastest tick spacing hides.
    always @(posedge clk) begin
        if (rst) begin
            cmp_hi <= 1'b0;
            pcnt   <= 0;
            ptick  <= 1'b0;
        end else begin
            cmp_hi <= (analog >= dac);
            pcnt   <= (pcnt == 2) ? 0 : pcnt + 1;
            ptick  <= (pcnt == 2);
        end
    end

    // =========================================================================
    // Bus tasks and comparisons
    // =========================================================================
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: word %h, wanted %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, g, e);
        end
    endtask : chk_bit

    task automatic final_report;
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // =========================================================================
    // One conversion at a given clock choice, then stop and inspect results
    // =========================================================================
    task automatic convert(input logic [1:0] fr, input logic [9:0] val, input int d);
        int k;
        int tol;
        tol = (fr == 2'b11) ? 3 : 2;
        analog <= val;
        wr_reg(OFF_MODE, {24'h0, 1'b1, 3'h0, fr, 2'h0});
        @(posedge clk);
        #1;
        k = 1;
        while (smp === 1'b1 && k < 400) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_bit(k >= 9 * d - tol && k <= 9 * d + tol, 1'b1);
        chk_word({22'h0, dac}, 32'h200);
        k = 0;
        while (smp !== 1'b1 && k < 400) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_bit(k >= 10 * d - tol && k <= 10 * d + tol, 1'b1);
        rd_reg(OFF_RESULT, got);
        chk_word(got, {16'h0, val, 6'h0});
        rd_reg(OFF_RESULT_HI, got);
        chk_word(got, {24'h0, val[9:2]});
        wr_reg(OFF_MODE_CLR, 32'h7);
        rd_reg(OFF_IRQ_STS, got);
        chk_word(got, {30'h0, val[9:2] < 8'h60, 1'b1});
        wr_reg(OFF_IRQ_MSK, 32'h1);
        #1;
        chk_bit(irq, 1'b1);
        wr_reg(OFF_IRQ_MSK, 32'h0);
        #1;
        chk_bit(irq, 1'b0);
        wr_reg(OFF_IRQ_STS, 32'h3);
        rd_reg(OFF_IRQ_STS, got);
        chk_word(got, 32'h0);
    endtask : convert

    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        pins = 16'hffff;
        analog = '0;
        bad_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFF_THRESH, got);
        chk_word(got, 32'h0);
        rd_reg(OFF_MODE, got);
        chk_word(got, 32'h0);
        chk_bit(irq, 1'b0);
        wr_reg(OFF_THRESH, 32'ha5);
        rd_reg(OFF_THRESH, got);
        chk_word(got, 32'ha5);
        // Every writable and fixed mode bit is hit, so the converter must stay idle.
        wr_reg(OFF_MODE, 32'hff);
        rd_reg(OFF_MODE, got);
        chk_word(got, 32'hbc);
        repeat (20) @(posedge clk);
        chk_bit(busy, 1'b0);
        wr_reg(OFF_MODE, 32'h08);
        repeat (20) @(posedge clk);
        chk_bit(busy, 1'b0);
        wr_reg(OFF_MODE_SET, 32'h7);
        rd_reg(OFF_MODE, got);
        chk_word(got, 32'h88);
        chk_bit(busy, 1'b1);
        wr_reg(OFF_CHAN, 32'h5);
        wr_reg(OFF_CHAN, 32'h10);
        #1;
        chk_word({28'h0, chan}, 32'h5);
        chk_word({16'h0, port_data}, 32'hffdf);
        wr_reg(OFF_MODE_CLR, 32'h7);
        rd_reg(OFF_MODE, got);
        chk_word(got, 32'h08);
        chk_word({16'h0, port_data}, 32'hffff);
        wr_reg(OFF_IRQ_STS, 32'h3);
        wr_reg(OFF_THRESH, 32'h60);
        convert(2'b00, 10'h000, 16);
        convert(2'b01, 10'h155, 8);
        convert(2'b10, 10'h3ff, 4);
        convert(2'b11, 10'h2aa, 3);
        wr_reg(OFF_RESULT, 32'hffffffff);
        rd_reg(OFF_RESULT, got);
        chk_word(got, {16'h0, 10'h2aa, 6'h0});
        rd_reg(8'hfc, got);
        chk_word(got, 32'h0);
        final_report;
    end

    // The whole sequence needs under a thousand clocks; this limit of 40000 clocks leaves wide margin.
    initial begin
        #(40 * 40000);
        bad_count++;
        final_report;
    end

endmodule : tb
